// >>> host_port_pkg.sv
// shared constants and types for the host control port front end.
// assumes a single host clock domain; straps are static after reset.
package host_port_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // access latency in host clock cycles, picked from the address
  localparam int LAT_MIN = 3;
  localparam int LAT_MAX = 9;
  localparam logic [3:0] LAT_MIN_4 = 4'h3;
  // serial command word layout
  localparam int CMD_READ_BIT = 15;
  localparam int CMD_ADDR_LSB = 0;
  // strap encodings and the last bit index of a serial word
  localparam logic STYLE_STROBES = 1'h0;
  localparam logic STYLE_DATA_STROBE = 1'h1;
  localparam logic SERIAL_SPI = 1'h0;
  localparam logic SERIAL_FRAME_SYNC = 1'h1;
  localparam logic ORDER_MSB_FIRST = 1'h0;
  localparam logic [4:0] WORD_LAST_BIT = 5'h0f;

  typedef enum {P_IDLE, P_WAIT, P_DONE} par_state_t;
  typedef enum {S_IDLE, S_CMD, S_DATA, S_READ, S_HOLD} ser_state_t;
endpackage : host_port_pkg

// >>> shift_if.sv
// carrier between the port controller and its serial shift registers.
// assumes one controller drives each instance.
`timescale 1ns/10ps
interface shift_if #(parameter int W = 16);
  logic load;
  logic [W-1:0] load_data;
  logic shift;
  logic lsb_first;
  logic sin;
  logic [W-1:0] q;
  logic sout;
  modport ctrl(output load, load_data, shift, lsb_first, sin,
               input q, sout);
  modport shifter(input load, load_data, shift, lsb_first, sin,
                  output q, sout);
endinterface : shift_if

// >>> serial_shifter.sv
// one serial shift register whose direction follows the bit-order strap.
// assumes the controller holds lsb_first steady across a word.
`timescale 1ns/10ps
module serial_shifter #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  shift_if.shifter sh
);
  typedef struct packed {
    logic [W-1:0] q;
  } shift_state_t;

  shift_state_t state_r;
  shift_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (sh.load) begin
      state_nxt.q = sh.load_data;
    end else if (sh.shift) begin
      if (sh.lsb_first) begin
        state_nxt.q = {sh.sin, state_r.q[W-1:1]};
      end else begin
        state_nxt.q = {state_r.q[W-2:0], sh.sin};
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sh.q = state_r.q;
  // first bit out is the end opposite the one the word is refilled from
  assign sh.sout = sh.lsb_first ? state_r.q[0] : state_r.q[W-1];
endmodule : serial_shifter

// >>> host_control_port_select.sv
// host control port front end: parallel microport or serial port,
// chosen by straps. assumes all pins are synchronous to clock and the
// internal register side answers reg_rdata in the cycle reg_rd is high.
`timescale 1ns/10ps
module host_control_port_select #(
  parameter int ADDR_W = host_port_pkg::ADDR_W,
  parameter int DATA_W = host_port_pkg::DATA_W
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_select_strap,
  input wire logic style_strap,
  input wire logic bit_order_strap,
  input wire logic chip_select_n,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [DATA_W-1:0] host_data_in,
  output logic [DATA_W-1:0] host_data_out,
  output logic [DATA_W-1:0] host_data_oe,
  input wire logic host_data_strobe_n,
  input wire logic host_direction,
  output logic host_transfer_ack_n,
  input wire logic serial_select_n,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic serial_rx_frame_sync,
  input wire logic serial_tx_frame_sync,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata
);
  if (DATA_W != 16 || ADDR_W < 3 || ADDR_W > 16) begin : g_check
    $error("host_control_port_select: unsupported bus widths");
  end

  typedef struct packed {
    logic straps_ok;
    logic ser_mode;
    logic style;
    logic lsb_first;
    host_port_pkg::par_state_t pst;
    logic [3:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic rd;
    logic [DATA_W-1:0] rdata;
    logic drive;
    logic ack_n;
    logic reg_wr;
    logic reg_rd;
    host_port_pkg::ser_state_t sst;
    logic [4:0] bits;
    logic tx_pend;
    logic tx_on;
    logic [4:0] tx_bits;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  shift_if #(.W(DATA_W)) rx_sh();
  shift_if #(.W(DATA_W)) tx_sh();

  serial_shifter #(.W(DATA_W)) u_rx (
    .clock(clock),
    .reset_n(reset_n),
    .sh(rx_sh.shifter)
  );
  serial_shifter #(.W(DATA_W)) u_tx (
    .clock(clock),
    .reset_n(reset_n),
    .sh(tx_sh.shifter)
  );

  logic strobe;
  logic is_read;
  logic par_start;
  logic par_release;
  logic [3:0] latency;
  logic spi;
  logic frame_on;
  logic [DATA_W-1:0] full_word;

  // latency grows with the top address bits and saturates at the maximum
  function automatic logic [3:0] access_latency(
    input logic [ADDR_W-1:0] a
  );
    logic [2:0] sel;
    sel = a[ADDR_W-1 -: 3];
    if (sel > 3'h6) begin
      sel = 3'h6;
    end
    access_latency = host_port_pkg::LAT_MIN_4 + {1'h0, sel};
  endfunction : access_latency

  always_comb begin
    // decode the shared strobe pins according to the style strap
    if (state_r.style == host_port_pkg::STYLE_DATA_STROBE) begin
      strobe = !host_data_strobe_n;
      is_read = host_direction;
    end else begin
      strobe = !host_data_strobe_n || !host_direction;
      is_read = !host_data_strobe_n;
    end
    par_start = state_r.straps_ok && !state_r.ser_mode &&
                !chip_select_n && strobe;
    par_release = !strobe;
    latency = access_latency(host_addr);
    spi = state_r.style == host_port_pkg::SERIAL_SPI;
    frame_on = !serial_select_n;
    // the word as it will stand once the current bit is shifted in
    if (state_r.lsb_first) begin
      full_word = {serial_in, rx_sh.q[DATA_W-1:1]};
    end else begin
      full_word = {rx_sh.q[DATA_W-2:0], serial_in};
    end
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.reg_wr = 1'h0;
    state_nxt.reg_rd = 1'h0;
    rx_sh.load = 1'h0;
    rx_sh.load_data = '0;
    rx_sh.shift = 1'h0;
    rx_sh.lsb_first = state_r.lsb_first;
    rx_sh.sin = serial_in;
    tx_sh.load = 1'h0;
    tx_sh.load_data = reg_rdata;
    tx_sh.shift = 1'h0;
    tx_sh.lsb_first = state_r.lsb_first;
    tx_sh.sin = 1'h0;

    // straps are caught once, on the first edge after reset release
    if (!state_r.straps_ok) begin
      state_nxt.straps_ok = 1'h1;
      state_nxt.ser_mode = serial_select_strap;
      state_nxt.style = style_strap;
      state_nxt.lsb_first = bit_order_strap != host_port_pkg::ORDER_MSB_FIRST;
    end

    // parallel microport
    case (state_r.pst)
      host_port_pkg::P_IDLE: begin
        if (par_start) begin
          state_nxt.pst = host_port_pkg::P_WAIT;
          state_nxt.cnt = latency - 4'h1;
          state_nxt.addr = host_addr;
          state_nxt.wdata = host_data_in;
          state_nxt.rd = is_read;
        end
      end
      host_port_pkg::P_WAIT: begin
        state_nxt.cnt = state_r.cnt - 4'h1;
        if (state_r.cnt == 4'h1) begin
          state_nxt.reg_rd = state_r.rd;
          state_nxt.reg_wr = !state_r.rd;
        end
        if (state_r.cnt == 4'h0) begin
          state_nxt.pst = host_port_pkg::P_DONE;
          if (state_r.rd) begin
            state_nxt.rdata = reg_rdata;
            state_nxt.drive = 1'h1;
          end
        end
      end
      host_port_pkg::P_DONE: begin
        if (par_release) begin
          state_nxt.pst = host_port_pkg::P_IDLE;
          state_nxt.drive = 1'h0;
        end
      end
      default: begin
        state_nxt.pst = host_port_pkg::P_IDLE;
      end
    endcase

    // acknowledge in style 1, ready (high when free) in style 0
    if (state_r.ser_mode) begin
      state_nxt.ack_n = 1'h1;
    end else if (state_r.style == host_port_pkg::STYLE_DATA_STROBE) begin
      state_nxt.ack_n = state_nxt.pst != host_port_pkg::P_DONE;
    end else begin
      state_nxt.ack_n = state_nxt.pst != host_port_pkg::P_WAIT;
    end

    // serial port receive side
    if (!state_r.ser_mode || !state_r.straps_ok) begin
      state_nxt.sst = host_port_pkg::S_IDLE;
    end else if (spi && !frame_on) begin
      // spi frame ended early: drop whatever was half done
      state_nxt.sst = host_port_pkg::S_IDLE;
      state_nxt.tx_on = 1'h0;
      state_nxt.tx_pend = 1'h0;
    end else begin
      case (state_r.sst)
        host_port_pkg::S_IDLE: begin
          if (spi) begin
            rx_sh.shift = 1'h1;
            state_nxt.bits = 5'h1;
            state_nxt.sst = host_port_pkg::S_CMD;
          end else if (frame_on && serial_rx_frame_sync) begin
            state_nxt.bits = 5'h0;
            state_nxt.sst = host_port_pkg::S_CMD;
          end
        end
        host_port_pkg::S_CMD: begin
          rx_sh.shift = 1'h1;
          state_nxt.bits = state_r.bits + 5'h1;
          if (state_r.bits == host_port_pkg::WORD_LAST_BIT) begin
            state_nxt.addr = full_word[host_port_pkg::CMD_ADDR_LSB +: ADDR_W];
            state_nxt.rd = full_word[host_port_pkg::CMD_READ_BIT];
            state_nxt.bits = 5'h0;
            if (full_word[host_port_pkg::CMD_READ_BIT]) begin
              state_nxt.reg_rd = 1'h1;
              state_nxt.sst = host_port_pkg::S_READ;
            end else begin
              state_nxt.sst = host_port_pkg::S_DATA;
            end
          end
        end
        host_port_pkg::S_DATA: begin
          rx_sh.shift = 1'h1;
          state_nxt.bits = state_r.bits + 5'h1;
          if (state_r.bits == host_port_pkg::WORD_LAST_BIT) begin
            state_nxt.wdata = full_word;
            state_nxt.reg_wr = 1'h1;
            state_nxt.sst = spi ? host_port_pkg::S_HOLD
                                : host_port_pkg::S_IDLE;
          end
        end
        host_port_pkg::S_READ: begin
          tx_sh.load = 1'h1;
          state_nxt.tx_pend = 1'h1;
          state_nxt.sst = spi ? host_port_pkg::S_HOLD
                              : host_port_pkg::S_IDLE;
        end
        host_port_pkg::S_HOLD: begin
          state_nxt.sst = host_port_pkg::S_HOLD;
        end
        default: begin
          state_nxt.sst = host_port_pkg::S_IDLE;
        end
      endcase
    end

    // serial transmit: spi sends at once, frame-sync waits for its sync
    if (state_r.tx_on && !(spi && !frame_on)) begin
      tx_sh.shift = 1'h1;
      state_nxt.tx_bits = state_r.tx_bits + 5'h1;
      if (state_r.tx_bits == host_port_pkg::WORD_LAST_BIT) begin
        state_nxt.tx_on = 1'h0;
      end
    end else if (state_r.tx_pend && !tx_sh.load &&
                 (spi || (frame_on && serial_tx_frame_sync))) begin
      state_nxt.tx_pend = 1'h0;
      state_nxt.tx_on = 1'h1;
      state_nxt.tx_bits = 5'h0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // everything returns to idle with the bus released
      state_r <= '0;
      state_r.pst <= host_port_pkg::P_IDLE;
      state_r.sst <= host_port_pkg::S_IDLE;
      state_r.ack_n <= 1'h1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign host_data_out = state_r.rdata;
  // gated by chip select directly so deselect releases the bus at once
  assign host_data_oe = {DATA_W{state_r.drive && !chip_select_n}};
  assign host_transfer_ack_n = state_r.ack_n;
  assign serial_out = state_r.tx_on && tx_sh.sout;
  assign reg_addr = state_r.addr;
  assign reg_wdata = state_r.wdata;
  assign reg_wr = state_r.reg_wr;
  assign reg_rd = state_r.reg_rd;
endmodule : host_control_port_select

// >>> host_port_assertions.sv
// pin-level assertions for host_control_port_select.
// assumes straps hold steady while reset is released.
`timescale 1ns/10ps
module host_port_assertions #(
  parameter int DATA_W = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic serial_select_strap,
  input wire logic style_strap,
  input wire logic chip_select_n,
  input wire logic [DATA_W-1:0] host_data_oe,
  input wire logic host_data_strobe_n,
  input wire logic host_transfer_ack_n,
  input wire logic serial_out,
  input wire logic reg_wr,
  input wire logic reg_rd
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic par1 = !serial_select_strap && style_strap;
  wire logic par0 = !serial_select_strap && !style_strap;
  property p_oe_cs;
    chip_select_n |-> host_data_oe == '0;
  endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("bus driven");
  property p_ser_quiet;
    serial_select_strap |-> host_data_oe == '0 && host_transfer_ack_n;
  endproperty
  a_ser_quiet: assert property (p_ser_quiet) else $error("par busy");
  property p_par_sout;
    !serial_select_strap |-> !serial_out;
  endproperty
  a_par_sout: assert property (p_par_sout) else $error("sout busy");
  property p_ack_cause;
    par1 && $fell(host_transfer_ack_n) |-> $past(reg_rd) || $past(reg_wr);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("no pulse");
  property p_s0_busy;
    par0 && $fell(host_transfer_ack_n) |->
      !host_transfer_ack_n [*3] ##[1:7] host_transfer_ack_n;
  endproperty
  a_s0_busy: assert property (p_s0_busy) else $error("ready len");
  property p_lat;
    par1 && !chip_select_n && $fell(host_data_strobe_n) && host_transfer_ack_n
      |-> host_transfer_ack_n [*4] ##[1:7] !host_transfer_ack_n;
  endproperty
  a_lat: assert property (p_lat) else $error("ack latency");
  property p_s1_hold;
    par1 && !host_transfer_ack_n && !host_data_strobe_n
      |=> !host_transfer_ack_n;
  endproperty
  a_s1_hold: assert property (p_s1_hold) else $error("ack dropped");
  property p_rst;
    $rose(reset_n) |-> host_data_oe == '0 && host_transfer_ack_n && !reg_rd;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle");
endmodule : host_port_assertions
bind host_control_port_select host_port_assertions #(.DATA_W(DATA_W)) chk_i (
  .clock, .reset_n, .serial_select_strap, .style_strap, .chip_select_n,
  .host_data_oe, .host_data_strobe_n, .host_transfer_ack_n, .serial_out,
  .reg_wr, .reg_rd);

// >>> host_model.sv
// behavioural host processor on the parallel and serial pins.
// assumes its tasks are entered at a falling clock edge.
`timescale 1ns/10ps
module host_model (
  input wire logic clock,
  input wire logic host_transfer_ack_n,
  output logic chip_select_n,
  output logic [7:0] host_addr,
  output logic [15:0] host_data_in,
  output logic host_data_strobe_n,
  output logic host_direction,
  output logic serial_select_n,
  output logic serial_in,
  output logic serial_rx_frame_sync,
  output logic serial_tx_frame_sync
);
  initial begin
    {chip_select_n, host_data_strobe_n, host_direction} = 3'h7;
    serial_select_n = 1'b1;
    {host_addr, host_data_in, serial_in} = '0;
    {serial_rx_frame_sync, serial_tx_frame_sync} = 2'h0;
  end
  task start(input logic y, input logic wr, input logic [7:0] a,
             input logic [15:0] d);
    chip_select_n = 1'b0;
    host_addr = a;
    host_data_in = d;
    host_data_strobe_n = y ? 1'b0 : wr;
    host_direction = !wr;
  endtask : start
  task wait_done(input logic y, output int lat);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (n < 12 && (y ? host_transfer_ack_n
                            : (n < 2 || !host_transfer_ack_n)));
    lat = n - 1;
  endtask : wait_done
  // lines left behind are inverted so a stale value cannot pass
  task release_bus(input logic y);
    host_data_strobe_n = 1'b1;
    if (!y) host_direction = 1'b1;
    repeat (2) @(negedge clock);
    chip_select_n = 1'b1;
    host_addr = ~host_addr;
    host_data_in = ~host_data_in;
    // one edge with the port deselected before any next access
    @(negedge clock);
  endtask : release_bus
  // one-cycle transmit sync to start pending read data
  task tx_sync();
    serial_tx_frame_sync = 1'b1;
    @(negedge clock);
    serial_tx_frame_sync = 1'b0;
  endtask : tx_sync
  task ser(input logic fs, input logic lsb, input logic [31:0] w, input int n);
    serial_select_n = 1'b0;
    if (fs) begin
      serial_rx_frame_sync = 1'b1;
      @(negedge clock);
      serial_rx_frame_sync = 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      serial_in = w[31 - 16 * (i / 16) - (lsb ? 15 - i % 16 : i % 16)];
      @(negedge clock);
    end
    serial_in = ~serial_in;
  endtask : ser
  // the data-in pin has a pull-down, so it rests low once deselected
  task deselect();
    serial_select_n = 1'b1;
    serial_in = 1'b0;
    repeat (2) @(negedge clock);
  endtask : deselect
endmodule : host_model

// >>> tb.sv
// self-checking bench for host_control_port_select driven by host_model.
// assumes the register side answers in the read pulse cycle.
`timescale 1ns/10ps
module tb;
  logic clock, reset_n, serial_select_strap, style_strap, bit_order_strap;
  logic chip_select_n, host_data_strobe_n, host_direction, serial_select_n;
  logic serial_in, serial_rx_frame_sync, serial_tx_frame_sync, serial_out;
  logic host_transfer_ack_n, reg_wr, reg_rd;
  logic [7:0] host_addr, reg_addr, cap_a;
  logic [15:0] host_data_in, host_data_out, host_data_oe;
  logic [15:0] reg_wdata, reg_rdata, cap_w, got;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_wr = 0;
  int n_rd = 0;
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  assign reg_rdata = {8'h5a, reg_addr};
  host_model host (.clock, .host_transfer_ack_n, .chip_select_n, .host_addr,
    .host_data_in, .host_data_strobe_n, .host_direction, .serial_select_n,
    .serial_in, .serial_rx_frame_sync, .serial_tx_frame_sync);
  host_control_port_select dut (.clock, .reset_n, .serial_select_strap,
    .style_strap, .bit_order_strap, .chip_select_n, .host_addr, .host_data_in,
    .host_data_out, .host_data_oe, .host_data_strobe_n, .host_direction,
    .host_transfer_ack_n, .serial_select_n, .serial_in, .serial_out,
    .serial_rx_frame_sync, .serial_tx_frame_sync, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  always @(posedge clock) begin
    cyc++;
    n_rd += reg_rd;
    if (reg_wr) begin
      n_wr++;
      {cap_a, cap_w} = {reg_addr, reg_wdata};
    end
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task grab(input logic lsb);
    for (int i = 0; i < 16; i++) begin
      got[lsb ? i : 15 - i] = serial_out;
      @(negedge clock);
    end
  endtask : grab
  task rst(input logic s, input logic y, input logic o);
    reset_n = 1'b0;
    {serial_select_strap, style_strap, bit_order_strap} = {s, y, o};
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    repeat (2) @(negedge clock);
  endtask : rst
  task par(input logic y, input logic wr, input logic [7:0] a,
           input logic [15:0] d);
    int lat, w0;
    w0 = n_wr;
    host.start(y, wr, a, d);
    host.wait_done(y, lat);
    chk(lat, 3 + ((a[7:5] > 3'h6) ? 3'h6 : a[7:5]));
    if (wr) chk({n_wr - w0, cap_a, cap_w}, {8'h1, a, d});
    else chk({host_data_oe, host_data_out}, {16'hffff, 8'h5a, a});
    chk(host_transfer_ack_n, !y);
    host.release_bus(y);
    chk({host_data_oe, host_transfer_ack_n}, 17'h1);
  endtask : par
  task t_parallel();
    int lat;
    par(1'b1, 1'b0, 8'h00, 16'h0);
    par(1'b1, 1'b0, 8'he0, 16'h0);
    par(1'b1, 1'b1, 8'h7f, 16'h1234);
    rst(1'b0, 1'b0, 1'b0);
    par(1'b0, 1'b1, 8'h41, 16'hbeef);
    par(1'b0, 1'b0, 8'hc3, 16'h0);
    host.start(1'b0, 1'b0, 8'h10, 16'h0);
    host.wait_done(1'b0, lat);
    host.chip_select_n = 1'b1;
    #1 chk(host_data_oe, 16'h0);
    host.release_bus(1'b0);
    $display("parallel done");
  endtask : t_parallel
  task t_abort();
    int r0;
    rst(1'b0, 1'b1, 1'b0);
    r0 = n_rd;
    host.start(1'b1, 1'b0, 8'he0, 16'h0);
    repeat (3) @(negedge clock);
    reset_n = 1'b0;
    #1 chk({host_data_oe, host_transfer_ack_n}, 17'h1);
    host.release_bus(1'b1);
    repeat (8) @(negedge clock);
    chk(n_rd - r0, 0);
    rst(1'b0, 1'b1, 1'b0);
    par(1'b1, 1'b0, 8'h20, 16'h0);
    $display("abort done");
  endtask : t_abort
  task t_serial();
    int w0;
    for (int f = 0; f < 2; f++) begin
      rst(1'b1, f[0], f[0]);
      w0 = n_wr;
      host.ser(f[0], f[0], 32'h0033c3a5, 32);
      repeat (3) @(negedge clock);
      chk({n_wr - w0, cap_a, cap_w}, 32'h0133c3a5);
      host.deselect();
    end
    host.start(1'b1, 1'b0, 8'h00, 16'h0);
    repeat (12) @(negedge clock);
    chk(host_transfer_ack_n, 1'b1);
    host.release_bus(1'b1);
    rst(1'b1, 1'b0, 1'b1);
    host.ser(1'b0, 1'b1, 32'h80570000, 16);
    repeat (2) @(negedge clock);
    grab(1'b1);
    chk(got, 16'h5a57);
    host.deselect();
    rst(1'b1, 1'b1, 1'b0);
    host.ser(1'b1, 1'b0, 32'h80e10000, 16);
    repeat (2) @(negedge clock);
    host.tx_sync();
    grab(1'b0);
    chk(got, 16'h5ae1);
    host.deselect();
    $display("serial done");
  endtask : t_serial
  initial begin
    rst(1'b0, 1'b1, 1'b0);
    t_parallel();
    t_abort();
    t_serial();
    end_sim();
  end
endmodule : tb
